// ### core/tmr_pkg.sv
// Purpose: shared constants and carriers for the 8-bit timer block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes: every register takes one aligned word; data in the low byte
package tmr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_COUNT = 5'h04;
  localparam logic [4:0] ADDR_RELOAD = 5'h08;
  localparam logic [4:0] ADDR_CTRL = 5'h0C;
  // Control register fields
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IEN_BIT = 1;
  localparam int CTRL_FAST_BIT = 3;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_FULL = 8'hFF;
  localparam logic [7:0] TOP_64 = 8'h3F;
  localparam logic [7:0] TOP_32 = 8'h1F;
  localparam logic [7:0] TOP_16 = 8'h0F;
  localparam logic [7:0] SLOW_MASK = 8'hFF;
  localparam logic [7:0] FAST_MASK = 8'h7F;
  localparam logic [7:0] IRQ_VECTOR = 8'h08;
  localparam int CPU_DIV_DEF = 4;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic ext_src;
    logic auto_reload;
    logic buzzer;
    logic pwm;
  } tmr_mode_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } tmr_av_req_t;
endpackage : tmr_pkg

// ### core/tmr_core.sv
// Purpose: 8-bit up timer/event counter with reload, PWM and buzzer
// Assumes: one 25 MHz clock; fast oscillator tick equals the clock
// Notes: instruction clock is the clock divided by CPU_DIV
//
// Contract
// - Eight-bit up counter, readable count value
// - Count one per selected clock, 256 steps
// - Hold when count enable clear, else count
// - Overflow FF to 00 sets sticky flag
// - Enabled overflow raises interrupt to vector 8
// - Auto-reload loads count from reload value
// - Reload value double buffered until overflow
// - Reload bit decides; PWM forces reload on
// - External source select counts event pin pulses
// - Slow source: instruction clock /256 down to /2
// - Fast source: oscillator /128 down to /1
// - Event mode ignores prescale select field
// - Buzzer toggles each overflow, half rate
// - Prescale, bits and reload shape PWM
// - Green mode keeps running, never wakes system
// - PWM boundary 256, 64, 32, 16 by bits
// - Buzzer only without PWM; else pin GPIO
// - Event mode suppresses event pin interrupt
`timescale 1ns/1ps
module tmr_core #(
  parameter int CPU_DIV = tmr_pkg::CPU_DIV_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire tmr_pkg::tmr_av_req_t av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  input wire logic event_input_pin_i,
  input wire logic green_mode_i,
  output logic pwm_buzzer_pin_o,
  output logic pwm_buzzer_pin_oe_o,
  output logic irq_o,
  output logic [7:0] irq_vector_o,
  output logic wake_req_o,
  output logic event_irq_suppress_o
);
  import tmr_pkg::*;

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (CPU_DIV < 1 || CPU_DIV > 256)
  begin : g_bad_div
    $error("CPU_DIV must lie in 1..256");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  tmr_mode_t mode_q;
  logic [7:0] count_value_q, count_value_d;
  logic [7:0] reload_buf_q, reload_act_q;
  logic overflow_flag_q, overflow_irq_enable_q, fast_clock_select_q;
  logic [7:0] cpu_div_q, pre_q;
  logic [2:0] evt_sync_q;
  logic buzz_q, pwm_q, pin_q, pin_oe_q;
  logic rd_vld_q;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_lo = av_req_i.write && av_req_i.byteenable[0];
  wire wr_mode = wr_lo && av_req_i.address == ADDR_MODE;
  wire wr_count = wr_lo && av_req_i.address == ADDR_COUNT;
  wire wr_reload = wr_lo && av_req_i.address == ADDR_RELOAD;
  wire wr_ctrl = wr_lo && av_req_i.address == ADDR_CTRL;
  wire [7:0] wbyte = av_req_i.writedata[7:0];
  // Flag clears only when software writes a zero there
  wire flag_clr = wr_ctrl && !wbyte[CTRL_FLAG_BIT];

  // Reads answer one cycle later; writes never wait
  assign av_waitrequest_o = av_req_i.read && !rd_vld_q;
  assign av_readdata_o = rdata_q;

  // Reload value is write-only, so it reads as zero
  wire [31:0] rd_mux =
    av_req_i.address == ADDR_MODE ? {24'h00_0000, mode_q} :
    av_req_i.address == ADDR_COUNT ? {24'h00_0000, count_value_q} :
    av_req_i.address == ADDR_CTRL ?
      {28'h000_0000, fast_clock_select_q, 1'b0,
       overflow_irq_enable_q, overflow_flag_q} :
    UNMAPPED_DATA;

  // ----------------------------------------
  // Clock sources and prescaler
  // ----------------------------------------
  localparam logic [7:0] CPU_LAST = 8'(CPU_DIV - 1);
  wire cpu_tick = cpu_div_q == CPU_LAST;
  wire base_tick = fast_clock_select_q ? 1'b1 : cpu_tick;
  // Mask shrinks by one bit per code step
  wire [7:0] pre_mask = fast_clock_select_q ? (FAST_MASK >> mode_q.rate)
                                            : (SLOW_MASK >> mode_q.rate);
  wire int_tick = base_tick && ((pre_q & pre_mask) == pre_mask);
  // Rising edge on the synchronised pin; first stage read only by second
  wire evt_edge = evt_sync_q[1] && !evt_sync_q[2];
  wire src_tick = mode_q.ext_src ? evt_edge : int_tick;
  wire tick = mode_q.enable && src_tick;

  // ----------------------------------------
  // Overflow boundary and reload
  // ----------------------------------------
  wire [7:0] pwm_top = !mode_q.auto_reload ?
                       (mode_q.buzzer ? TOP_64 : CNT_FULL) :
                       (mode_q.buzzer ? TOP_16 : TOP_32);
  wire [7:0] top = mode_q.pwm ? pwm_top : CNT_FULL;
  wire ovf = tick && count_value_q == top;
  wire reload_on = mode_q.pwm || mode_q.auto_reload;
  wire buzz_eff = mode_q.buzzer && !mode_q.pwm;

  // Next count: software write wins, then overflow, then step
  always_comb
  begin
    count_value_d = count_value_q;
    if (wr_count)
      count_value_d = wbyte;
    else if (ovf)
      count_value_d = reload_on ? reload_buf_q : RST_BYTE;
    else if (tick)
      count_value_d = 8'(count_value_q + 8'h01);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Divider and prescaler run freely, so rate changes take effect fast
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cpu_div_q <= RST_BYTE;
      pre_q <= RST_BYTE;
      evt_sync_q <= 3'b000;
    end
    else
    begin
      cpu_div_q <= cpu_tick ? RST_BYTE : 8'(cpu_div_q + 8'h01);
      if (base_tick)
        pre_q <= 8'(pre_q + 8'h01);
      evt_sync_q <= {evt_sync_q[1:0], event_input_pin_i};
    end
  end

  // Software-visible state; all clear at reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= '0;
      count_value_q <= RST_BYTE;
      reload_buf_q <= RST_BYTE;
      overflow_flag_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      fast_clock_select_q <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        mode_q <= wbyte;
      count_value_q <= count_value_d;
      if (wr_reload)
        reload_buf_q <= wbyte;
      // Set wins over a clear in the same cycle
      overflow_flag_q <= ovf || (overflow_flag_q && !flag_clr);
      if (wr_ctrl)
      begin
        overflow_irq_enable_q <= wbyte[CTRL_IEN_BIT];
        fast_clock_select_q <= wbyte[CTRL_FAST_BIT];
      end
    end
  end

  // Active duty copy moves only at overflow or while stopped
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      reload_act_q <= RST_BYTE;
    else if (ovf || !mode_q.enable)
      reload_act_q <= reload_buf_q;
  end

  // ----------------------------------------
  // Waveforms and pin
  // ----------------------------------------
  // PWM restarts high while stopped so the first period is whole
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      buzz_q <= 1'b0;
      pwm_q <= 1'b1;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      if (ovf && buzz_eff)
        buzz_q <= !buzz_q;
      if (!mode_q.enable || ovf)
        pwm_q <= 1'b1;
      else if (count_value_q == reload_act_q)
        pwm_q <= 1'b0;
      pin_q <= mode_q.pwm ? pwm_q : buzz_q;
      pin_oe_q <= mode_q.pwm || buzz_eff;
    end
  end

  // Read data captured the cycle the read arrives
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_vld_q <= 1'b0;
      rdata_q <= UNMAPPED_DATA;
    end
    else
    begin
      rd_vld_q <= av_req_i.read && !rd_vld_q;
      if (av_req_i.read)
        rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Green mode does not change counting; it never raises a wake
  assign pwm_buzzer_pin_o = pin_q;
  assign pwm_buzzer_pin_oe_o = pin_oe_q;
  assign irq_o = overflow_flag_q && overflow_irq_enable_q;
  assign irq_vector_o = IRQ_VECTOR;
  assign wake_req_o = green_mode_i && 1'b0;
  assign event_irq_suppress_o = mode_q.ext_src;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_hold_stopped: assert property (
    !mode_q.enable && !wr_count |=> $stable(count_value_q))
    else $error("count moved while stopped");
  a_count_step: assert property (
    tick && !ovf && !wr_count |=>
      count_value_q == 8'($past(count_value_q) + 8'h01))
    else $error("count did not step by one");
  a_flag_set: assert property (
    ovf |=> overflow_flag_q)
    else $error("overflow did not set flag");
  a_flag_sticky: assert property (
    overflow_flag_q && !flag_clr |=> overflow_flag_q)
    else $error("flag dropped without clear");
  a_reload_load: assert property (
    ovf && reload_on && !wr_count |=>
      count_value_q == $past(reload_buf_q))
    else $error("reload not applied at overflow");
  a_irq_raise: assert property (
    ovf && overflow_irq_enable_q && !wr_ctrl |=> irq_o)
    else $error("interrupt missing after overflow");
  a_buzz_toggle: assert property (
    ovf && buzz_eff |=> ##1 pin_q != $past(pin_q, 2) || mode_q.pwm)
    else $error("buzzer pin did not toggle");
  a_pwm_match: assert property (
    mode_q.enable && !ovf && count_value_q == reload_act_q |=> !pwm_q)
    else $error("pwm not low at duty match");
  a_event_only: assert property (
    mode_q.ext_src && !evt_edge |-> !tick)
    else $error("event mode counted without edge");


  // ----------------------------------------
  // Further checks on flag, interrupt, count, reload, PWM, source, pin and wake
  // ----------------------------------------
  // A clear with no overflow in the same cycle empties the flag
  a_flag_clear: assert property (
    overflow_flag_q && flag_clr && !ovf |=> !overflow_flag_q)
    else $error("flag not cleared by software");
  // Interrupt stays quiet while masked
  a_irq_masked: assert property (
    !overflow_irq_enable_q |-> !irq_o)
    else $error("interrupt raised while masked");
  // Vector address never moves
  a_vector_const: assert property (
    irq_vector_o == IRQ_VECTOR)
    else $error("interrupt vector changed");
  // Without reload the count wraps to zero
  a_no_reload: assert property (
    ovf && !reload_on && !wr_count |=> count_value_q == RST_BYTE)
    else $error("count not zero after plain overflow");
  // Full count in timer mode always overflows on a tick
  a_full_wrap: assert property (
    tick && !mode_q.pwm && count_value_q == CNT_FULL |-> ovf)
    else $error("full count did not overflow");
  // Smallest PWM boundary with both selection bits set
  a_pwm_top: assert property (
    mode_q.pwm && mode_q.auto_reload && mode_q.buzzer |-> top == TOP_16)
    else $error("wrong pwm boundary");
  // PWM returns high at each overflow
  a_pwm_restart: assert property (
    mode_q.enable && ovf |=> pwm_q)
    else $error("pwm not high after overflow");
  // Active duty must not move mid-period
  a_duty_hold: assert property (
    mode_q.enable && !ovf |=> $stable(reload_act_q))
    else $error("duty copy changed mid-period");
  // Slow source only ticks on an instruction clock tick
  a_slow_tick: assert property (
    !mode_q.ext_src && !fast_clock_select_q && int_tick |-> cpu_tick)
    else $error("slow source ticked off the instruction clock");
  // Pin is driven while either waveform is selected
  a_oe_on: assert property (
    mode_q.pwm || buzz_eff |=> pwm_buzzer_pin_oe_o)
    else $error("pin not driven with output on");
  // Pin is released to general use otherwise
  a_oe_off: assert property (
    !mode_q.pwm && !buzz_eff |=> !pwm_buzzer_pin_oe_o)
    else $error("pin driven with outputs off");
  // Buzzer holds when it has no effect
  a_buzz_quiet: assert property (
    !buzz_eff |=> $stable(buzz_q))
    else $error("buzzer toggled while disabled");
  // Timer never asks for a wake
  a_wake_never: assert property (
    !wake_req_o)
    else $error("timer requested a wake");
  // Event mode suppresses the pin's own request
  a_suppress_mode: assert property (
    event_irq_suppress_o == mode_q.ext_src)
    else $error("event suppress wrong");

  c_overflow_irq: cover property (ovf && overflow_irq_enable_q);
  c_buzz_toggle: cover property (ovf && buzz_eff);
  c_pwm_cycle: cover property (mode_q.pwm && ovf ##[1:300] !pwm_q);
  c_event_count: cover property (mode_q.ext_src && tick);
  c_set_clear: cover property (ovf && flag_clr);
endmodule : tmr_core

// ### verification/tmr_event_src.sv
// Purpose: external pulse source on the event input pin
// Assumes: pulses long enough for a two-stage synchronizer
// Notes: pin rests low between bursts
`timescale 1ns/1ps
module tmr_event_src (
  input wire logic ref_clk_i,
  output logic event_input_pin_o
);
  // ----------------------------------------
  // Pulse bursts
  // ----------------------------------------
  initial event_input_pin_o = 1'b0;
  // Three clocks high and four low, so no edge is lost in sync
  task automatic burst(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      event_input_pin_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      event_input_pin_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
    end
  endtask : burst
endmodule : tmr_event_src

// ### verification/timer_counter_pwm_buzzer_test.sv
// Purpose: self-checking bench for the 8-bit timer block
// Assumes: CPU_DIV of 4, fast tick equals the clock
// Notes: reads queue their expected data; a monitor compares
`timescale 1ns/1ps
module timer_counter_pwm_buzzer_test;
  import tmr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  tmr_av_req_t req = '0;
  logic [31:0] rdata;
  logic wreq;
  logic ev_pin;
  logic green = 1'b0;
  logic pin_o;
  logic pin_oe;
  logic irq;
  logic [7:0] vec;
  logic wake;
  logic supp;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  logic [7:0] v;
  logic [31:0] expq[$];
  // ----------------------------------------
  // Clock, design and pulse source
  // ----------------------------------------
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  tmr_core #(.CPU_DIV(4)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .av_req_i(req), .av_readdata_o(rdata), .av_waitrequest_o(wreq),
    .event_input_pin_i(ev_pin), .green_mode_i(green),
    .pwm_buzzer_pin_o(pin_o), .pwm_buzzer_pin_oe_o(pin_oe),
    .irq_o(irq), .irq_vector_o(vec), .wake_req_o(wake),
    .event_irq_suppress_o(supp));
  tmr_event_src src_u (.ref_clk_i(ref_clk_i), .event_input_pin_o(ev_pin));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic summarize();
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Monitor: completed read takes the oldest expectation
  always @(posedge ref_clk_i)
    if (req.read === 1'b1 && wreq === 1'b0)
      chk(rdata, expq.pop_front());
  // Bounded wait for waitrequest low at a rising edge
  task automatic ack();
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (wreq !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        n_fail++;
        summarize();
      end
      @(posedge ref_clk_i);
    end
  endtask : ack
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req.write <= 1'b1;
    req.address <= a;
    req.writedata <= {24'h00_0000, d};
    ack();
    req.write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expq.push_back({24'h00_0000, e});
    @(posedge ref_clk_i);
    req.read <= 1'b1;
    req.address <= a;
    ack();
    req.read <= 1'b0;
  endtask : rd
  // Waits for irq or a pin change; returns the cycle stamp
  task automatic wait_ev(input bit on_pin, output int t);
    int n;
    logic p;
    n = 0;
    p = pin_o;
    @(posedge ref_clk_i);
    while (on_pin ? pin_o === p : irq !== 1'b1)
    begin
      n++;
      if (n > 10000)
      begin
        n_fail++;
        summarize();
      end
      @(posedge ref_clk_i);
    end
    t = cyc;
  endtask : wait_ev
  // Overflow interval with count and reload at zero
  task automatic period(input logic [7:0] m, input logic f, input int e);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_RELOAD, 8'h00);
    wr(ADDR_CTRL, {4'h0, f, 3'b010});
    wr(ADDR_MODE, m);
    wait_ev(1'b0, t0);
    wr(ADDR_CTRL, {4'h0, f, 3'b010});
    wait_ev(1'b0, t1);
    chk(32'(t1 - t0), 32'(e));
    chk({31'h0, pin_oe}, {31'h0, m[0]});
  endtask : period
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    req.byteenable = 4'hF;
    void'($urandom(32'hEA0F_FCE6));
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(ADDR_MODE, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_RELOAD, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    rd(5'h10, 8'h00);
    chk({24'h00_0000, vec}, 32'h0000_0008);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, pin_oe}, 32'h0000_0000);
    v = 8'($urandom);
    wr(ADDR_COUNT, v);
    repeat (20) @(posedge ref_clk_i);
    rd(ADDR_COUNT, v);
    green <= 1'b1;
    period(8'hF0, 1'b0, 2048);
    period(8'hE0, 1'b0, 4096);
    period(8'hF0, 1'b1, 256);
    period(8'hD0, 1'b1, 1024);
    period(8'hF1, 1'b1, 256);
    period(8'hF3, 1'b1, 64);
    period(8'hF5, 1'b1, 32);
    period(8'hF7, 1'b1, 16);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_MODE, 8'hF2);
    wait_ev(1'b1, t0);
    wait_ev(1'b1, t1);
    chk(32'(t1 - t0), 32'd256);
    chk({31'h0, pin_oe}, 32'h0000_0001);
    chk({31'h0, wake}, 32'h0000_0000);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_COUNT, 8'hFF);
    wr(ADDR_RELOAD, 8'hA5);
    wr(ADDR_MODE, 8'hD4);
    wait_ev(1'b0, t0);
    rd(ADDR_COUNT, 8'hA5);
    rd(ADDR_CTRL, 8'h03);
    wr(ADDR_RELOAD, 8'h33);
    rd(ADDR_COUNT, 8'hA5);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h02);
    wait_ev(1'b0, t0);
    rd(ADDR_COUNT, 8'h33);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_COUNT, 8'hFF);
    // Flag still set from the last overflow; clear it or irq is stale
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_MODE, 8'hD0);
    wait_ev(1'b0, t0);
    rd(ADDR_COUNT, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_COUNT, 8'h00);
    v = 8'($urandom_range(20, 1));
    wr(ADDR_MODE, 8'hF8);
    src_u.burst(int'(v));
    repeat (6) @(posedge ref_clk_i);
    rd(ADDR_COUNT, v);
    chk({31'h0, supp}, 32'h0000_0001);
    summarize();
  end
endmodule : timer_counter_pwm_buzzer_test
